// ### logic/imp_irq_ctrl.sv
// Interrupt enable, priority and arbitration with a Wishbone register port.
//
// Overview of operation
// - Global enable bit 7 overrides all masks.
// - Source forwarded only while its mask is one.
// - Main enable at 0xA8, all pages, resets zero.
// - Main priority at 0xB8; bit 7 reads one.
// - Extended enable at 0xE6, all pages, resets zero.
// - Extended priority 0xF6 only on pages 0x00/0x0F.
// - Main bit 5 gates timer 2 low|high overflow.
// - Main bits 1/3 gate timer 0/1 overflow.
// - Main bits 0/2 gate external inputs 0/1.
// - Bit 6 sync serial, bit 4 async serial.
// - Extended bit 7 gates network controller flag.
// - Extended bit 6 gates timer 3 low|high overflow.
// - Bits 5/4 gate comparators, rise or fall.
// - Bit 2 conversion done, bit 1 window compare.
// - Bit 3 counter array, bit 0 management bus.
// - Main priority bits set level per source.
// - Extended priority bits set level per source.
// - High preempts low; high never preempted.
// - Higher level first, then fixed source order.
// - Sampled every cycle; one cycle detection.
`timescale 1ns/1ns
`default_nettype none
module imp_irq_ctrl
	import imp_pkg::*;
#(
	parameter int ADDR_W = 10
)
(
	input wire logic SYS_CLK_I,
	input wire logic ARST_N_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [ADDR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire imp_flags_s PEND_FLAGS_I,
	input wire logic SVC_ENTER_I,
	input wire logic SVC_RETURN_I,
	output imp_vec_t SRC_REQ_O,
	output imp_vec_t SRC_LEVEL_O,
	output imp_call_s CALL_O
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 10)
	begin : g_bad_addr
		$error("ADDR_W must be at least 10");
	end

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Register file and bus slave
	// ----------------------------------------------------------------
	logic [7:0] en_main_q, en_main_d;
	logic [7:0] lvl_main_q, lvl_main_d;
	logic [7:0] en_ext1_q, en_ext1_d;
	logic [7:0] lvl_ext1_q, lvl_ext1_d;
	logic [7:0] page_q, page_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [7:0] idx;
	logic page_ok;
	logic wr_now;
	assign idx = WB_ADR_I[9:2];
	assign page_ok = (page_q == IMP_PAGE_A) || (page_q == IMP_PAGE_B);
	// A write lands on the edge where the master sees the acknowledge.
	assign wr_now = WB_CYC_I && WB_STB_I && WB_WE_I && ack_q && WB_SEL_I[0];

	always_comb
	begin
		en_main_d = en_main_q;
		lvl_main_d = lvl_main_q;
		en_ext1_d = en_ext1_q;
		lvl_ext1_d = lvl_ext1_q;
		page_d = page_q;
		ack_d = WB_CYC_I && WB_STB_I && !ack_q;
		rdat_d = 32'h0;
		if (wr_now)
		begin
			case (idx)
				IMP_IDX_EN_MAIN: en_main_d = WB_DAT_I[7:0];
				IMP_IDX_LVL_MAIN: lvl_main_d = {1'b1, WB_DAT_I[6:0]};
				IMP_IDX_EN_EXT1: en_ext1_d = WB_DAT_I[7:0];
				IMP_IDX_LVL_EXT1: if (page_ok) lvl_ext1_d = WB_DAT_I[7:0];
				IMP_IDX_PAGE: page_d = WB_DAT_I[7:0];
				default: page_d = page_q;
			endcase
		end
		if (ack_d && !WB_WE_I)
		begin
			case (idx)
				IMP_IDX_EN_MAIN: rdat_d = {24'h0, en_main_q};
				IMP_IDX_LVL_MAIN: rdat_d = {24'h0, lvl_main_q};
				IMP_IDX_EN_EXT1: rdat_d = {24'h0, en_ext1_q};
				IMP_IDX_LVL_EXT1: rdat_d = page_ok ? {24'h0, lvl_ext1_q} : 32'h0;
				IMP_IDX_PAGE: rdat_d = {24'h0, page_q};
				default: rdat_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			en_main_q <= IMP_RST_EN_MAIN;
			lvl_main_q <= IMP_RST_LVL_MAIN;
			en_ext1_q <= IMP_RST_EN_EXT1;
			lvl_ext1_q <= IMP_RST_LVL_EXT1;
			page_q <= IMP_RST_PAGE;
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end
		else
		begin
			en_main_q <= en_main_d;
			lvl_main_q <= lvl_main_d;
			en_ext1_q <= en_ext1_d;
			lvl_ext1_q <= lvl_ext1_d;
			page_q <= page_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;

	// ----------------------------------------------------------------
	// Source gating and arbitration
	// ----------------------------------------------------------------
	imp_vec_t pend;
	imp_vec_t mask;
	imp_vec_t lvl;
	imp_vec_t req_d, req_q;
	imp_vec_t lvlo_q;
	imp_call_s call_d, call_q;
	logic hi_svc_q, hi_svc_d;
	logic lo_svc_q, lo_svc_d;
	logic glb;
	logic found_hi;
	logic found_lo;
	logic [3:0] idx_hi;
	logic [3:0] idx_lo;

	always_comb
	begin
		pend[0] = PEND_FLAGS_I.ext_input_zero;
		pend[1] = PEND_FLAGS_I.timer0_overflow_flag;
		pend[2] = PEND_FLAGS_I.ext_input_one;
		pend[3] = PEND_FLAGS_I.timer1_overflow_flag;
		pend[4] = PEND_FLAGS_I.async_serial;
		pend[5] = PEND_FLAGS_I.timer2_low_overflow_flag
			| PEND_FLAGS_I.timer2_high_overflow_flag;
		pend[6] = PEND_FLAGS_I.sync_serial;
		pend[7] = PEND_FLAGS_I.mgmt_bus_controller;
		pend[8] = PEND_FLAGS_I.window_cmp_flag;
		pend[9] = PEND_FLAGS_I.conv_done_flag;
		pend[10] = PEND_FLAGS_I.counter_array;
		pend[11] = PEND_FLAGS_I.comparator0_rise_flag
			| PEND_FLAGS_I.comparator0_fall_flag;
		pend[12] = PEND_FLAGS_I.comparator1_rise_flag
			| PEND_FLAGS_I.comparator1_fall_flag;
		pend[13] = PEND_FLAGS_I.timer3_low_overflow_flag
			| PEND_FLAGS_I.timer3_high_overflow_flag;
		pend[14] = PEND_FLAGS_I.net_ctrl_pending_flag;
	end

	// Main register bits 6:0 and extended bits 7:0 follow the fixed source order.
	assign mask = {en_ext1_q, en_main_q[IMP_MAIN_SRCS-1:0]};
	assign lvl = {lvl_ext1_q, lvl_main_q[IMP_MAIN_SRCS-1:0]};
	assign glb = en_main_q[IMP_GLOBAL_EN_BIT];
	assign req_d = pend & mask & {IMP_NUM_SRC{glb}};

	// Arbitration works on the registered requests, so a flag is seen one cycle
	// after it rises and the call is offered the cycle after that decode.
	always_comb
	begin
		found_hi = 1'b0;
		found_lo = 1'b0;
		idx_hi = 4'h0;
		idx_lo = 4'h0;
		for (int i = IMP_NUM_SRC - 1; i >= 0; i--)
		begin
			if (req_q[i] && lvlo_q[i])
			begin
				found_hi = 1'b1;
				idx_hi = 4'(i);
			end
			if (req_q[i] && !lvlo_q[i])
			begin
				found_lo = 1'b1;
				idx_lo = 4'(i);
			end
		end
		call_d = '0;
		if (found_hi && !hi_svc_q)
		begin
			call_d = '{req: 1'b1, high: 1'b1, src: idx_hi};
		end
		else if (found_lo && !hi_svc_q && !lo_svc_q)
		begin
			call_d = '{req: 1'b1, high: 1'b0, src: idx_lo};
		end
		hi_svc_d = hi_svc_q;
		lo_svc_d = lo_svc_q;
		if (SVC_RETURN_I)
		begin
			if (hi_svc_q)
				hi_svc_d = 1'b0;
			else
				lo_svc_d = 1'b0;
		end
		if (SVC_ENTER_I && call_q.req)
		begin
			if (call_q.high)
				hi_svc_d = 1'b1;
			else
				lo_svc_d = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			req_q <= '0;
			lvlo_q <= '0;
			call_q <= '0;
			hi_svc_q <= 1'b0;
			lo_svc_q <= 1'b0;
		end
		else
		begin
			req_q <= req_d;
			lvlo_q <= lvl;
			call_q <= call_d;
			hi_svc_q <= hi_svc_d;
			lo_svc_q <= lo_svc_d;
		end
	end
	assign SRC_REQ_O = req_q;
	assign SRC_LEVEL_O = lvlo_q;
	assign CALL_O = call_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!rst_n_q);

	// Requests, levels and calls are registered, so each check below but chk_lvl_top_one compares
	// against what the inputs and registers held one edge earlier, or two edges earlier for the flags in chk_detect_lat.
	chk_global_off: assert property (!glb |=> SRC_REQ_O == '0)
		else $error("request raised while global enable clear");
	chk_mask_gate: assert property (
		SRC_REQ_O == $past(pend & mask & {IMP_NUM_SRC{glb}}))
		else $error("request differs from flag, mask and global enable");
	chk_lvl_top_one: assert property (lvl_main_q[IMP_LVL_UNUSED_BIT])
		else $error("unused priority bit not one");
	chk_lvl_main_wr: assert property (
		wr_now && idx == IMP_IDX_LVL_MAIN
		|=> lvl_main_q == {1'b1, $past(WB_DAT_I[6:0])})
		else $error("main priority write lost");
	chk_en_main_wr: assert property (
		wr_now && idx == IMP_IDX_EN_MAIN |=> en_main_q == $past(WB_DAT_I[7:0]))
		else $error("main enable write lost");
	chk_en_ext_wr: assert property (
		wr_now && idx == IMP_IDX_EN_EXT1 |=> en_ext1_q == $past(WB_DAT_I[7:0]))
		else $error("extended enable write lost");
	chk_ext_lvl_wr: assert property (
		wr_now && idx == IMP_IDX_LVL_EXT1 && page_ok
		|=> lvl_ext1_q == $past(WB_DAT_I[7:0]))
		else $error("extended priority write lost on open page");
	chk_page_block: assert property (
		wr_now && idx == IMP_IDX_LVL_EXT1 && !page_ok |=> $stable(lvl_ext1_q))
		else $error("extended priority written on wrong page");
	chk_timer2_or: assert property (
		glb && en_main_q[5] && PEND_FLAGS_I.timer2_high_overflow_flag
		|=> SRC_REQ_O[5])
		else $error("timer 2 high flag not forwarded");
	chk_timer3_or: assert property (
		glb && en_ext1_q[6] && PEND_FLAGS_I.timer3_low_overflow_flag
		|=> SRC_REQ_O[13])
		else $error("timer 3 low flag not forwarded");
	chk_comp_or: assert property (
		glb && en_ext1_q[5] && PEND_FLAGS_I.comparator1_fall_flag
		|=> SRC_REQ_O[12])
		else $error("comparator 1 fall flag not forwarded");
	chk_level_map: assert property (
		SRC_LEVEL_O == $past({lvl_ext1_q, lvl_main_q[IMP_MAIN_SRCS-1:0]}))
		else $error("level vector does not follow priority registers");
	chk_no_preempt: assert property (hi_svc_q |=> !CALL_O.req)
		else $error("call offered during high-level service");
	chk_lo_blocked: assert property (
		lo_svc_q && !hi_svc_q |=> (!CALL_O.req || CALL_O.high))
		else $error("low call offered during low-level service");
	chk_high_first: assert property (
		CALL_O.req && !CALL_O.high |-> $past((req_q & lvlo_q) == '0))
		else $error("low call chosen over pending high request");
	chk_call_is_req: assert property (
		CALL_O.req |-> (($past(req_q) >> CALL_O.src) & 15'h1) != 15'h0)
		else $error("call names a source that was not requesting");
	chk_call_level: assert property (
		CALL_O.req
		|-> ((($past(lvlo_q) >> CALL_O.src) & 15'h1) != 15'h0) == CALL_O.high)
		else $error("call level differs from its source level");
	chk_fixed_order: assert property (
		CALL_O.req |-> (($past(req_q) & ($past(lvlo_q) ^ {IMP_NUM_SRC{!CALL_O.high}})
		& ((15'h1 << CALL_O.src) - 15'h1)) == '0))
		else $error("lower-numbered source of same level skipped");
	chk_detect_lat: assert property (
		glb && (pend & mask) != '0 && !hi_svc_q && !lo_svc_q && !SVC_ENTER_I
		##1 !SVC_ENTER_I |=> CALL_O.req)
		else $error("call not offered two edges after flag");
	chk_ack_one: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("acknowledge held for two cycles");

	// The covers show that both levels, a preemption and a blocked source are reached.
	cov_high_call: cover property (CALL_O.req && CALL_O.high);
	cov_low_call: cover property (CALL_O.req && !CALL_O.high);
	cov_preempt: cover property (lo_svc_q && CALL_O.req && CALL_O.high);
	cov_page_read: cover property (ack_d && !WB_WE_I && idx == IMP_IDX_LVL_EXT1 && page_ok);
	cov_all_off: cover property (!glb && pend != '0);
endmodule : imp_irq_ctrl
`default_nettype wire

// ### logic/imp_pkg.sv
// Constants and carrier types for the interrupt mask and priority block.
`default_nettype none
package imp_pkg;
	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IMP_IDX_EN_MAIN = 8'ha8;
	localparam logic [7:0] IMP_IDX_LVL_MAIN = 8'hb8;
	localparam logic [7:0] IMP_IDX_EN_EXT1 = 8'he6;
	localparam logic [7:0] IMP_IDX_LVL_EXT1 = 8'hf6;
	localparam logic [7:0] IMP_IDX_PAGE = 8'h84;
	// ----------------------------------------------------------------
	// Pages that expose the extended priority register
	// ----------------------------------------------------------------
	localparam logic [7:0] IMP_PAGE_A = 8'h00;
	localparam logic [7:0] IMP_PAGE_B = 8'h0f;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int IMP_GLOBAL_EN_BIT = 7;
	localparam int IMP_LVL_UNUSED_BIT = 7;
	localparam int IMP_MAIN_SRCS = 7;
	localparam int IMP_NUM_SRC = 15;
	localparam logic [7:0] IMP_RST_EN_MAIN = 8'h00;
	localparam logic [7:0] IMP_RST_LVL_MAIN = 8'h80;
	localparam logic [7:0] IMP_RST_EN_EXT1 = 8'h00;
	localparam logic [7:0] IMP_RST_LVL_EXT1 = 8'h00;
	localparam logic [7:0] IMP_RST_PAGE = 8'h00;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int IMP_DETECT_CYC = 1;
	localparam int IMP_CALL_CYC = 4;
	localparam int IMP_FAST_RESP_CYC = IMP_DETECT_CYC + IMP_CALL_CYC;
	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef logic [IMP_NUM_SRC-1:0] imp_vec_t;
	typedef struct packed {
		logic net_ctrl_pending_flag;
		logic timer3_high_overflow_flag;
		logic timer3_low_overflow_flag;
		logic comparator1_rise_flag;
		logic comparator1_fall_flag;
		logic comparator0_rise_flag;
		logic comparator0_fall_flag;
		logic counter_array;
		logic conv_done_flag;
		logic window_cmp_flag;
		logic mgmt_bus_controller;
		logic sync_serial;
		logic timer2_high_overflow_flag;
		logic timer2_low_overflow_flag;
		logic async_serial;
		logic timer1_overflow_flag;
		logic ext_input_one;
		logic timer0_overflow_flag;
		logic ext_input_zero;
	} imp_flags_s;
	typedef struct packed {
		logic req;
		logic high;
		logic [3:0] src;
	} imp_call_s;
endpackage : imp_pkg
`default_nettype wire

// ### tb/imp_cpu_model.sv
// Behavioural CPU sequencer that enters and leaves service routines.
`timescale 1ns/1ns
`default_nettype none
module imp_cpu_model
	import imp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire imp_call_s call_i,
	input wire logic take_i,
	input wire logic done_i,
	output logic enter_o,
	output logic return_o
);
	// ----------------------------------------------------------------
	// Service handshake
	// ----------------------------------------------------------------
	// Entry is only made while a call is on offer, as a real core would.
	// The guard on enter_o keeps a held command from entering twice.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			enter_o <= 1'b0;
			return_o <= 1'b0;
		end
		else
		begin
			enter_o <= take_i & call_i.req & ~enter_o;
			return_o <= done_i;
		end
	end
endmodule : imp_cpu_model
`default_nettype wire

// ### tb/test_interrupt_mask_priority_regs.sv
// Self-checking bench for the interrupt mask and priority block.
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_mask_priority_regs
	import imp_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic [31:0] got;
	logic ack;
	imp_flags_s flags = 19'h00000;
	logic take = 1'b0;
	logic done = 1'b0;
	logic enter;
	logic ret;
	imp_vec_t req;
	imp_vec_t lvl;
	imp_call_s call;
	int n_mismatch = 0;
	int samples_checked = 0;

	always #10 clk = ~clk;

	imp_irq_ctrl dut_u (
		.SYS_CLK_I(clk), .ARST_N_I(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .PEND_FLAGS_I(flags),
		.SVC_ENTER_I(enter), .SVC_RETURN_I(ret), .SRC_REQ_O(req),
		.SRC_LEVEL_O(lvl), .CALL_O(call)
	);

	imp_cpu_model cpu_u (
		.clk_i(clk), .rst_n_i(arst_n), .call_i(call), .take_i(take),
		.done_i(done), .enter_o(enter), .return_o(ret)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			n_mismatch++;
		end
	endtask : chk

	// One classic cycle; the request is held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		wdat <= {24'h000000, d};
		// Ack and read data come from flops, so they are looked at once settled and
		// stand unchanged at the next edge, where the master sees ack high.
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1)
		begin
			n_mismatch++;
			end_of_test();
		end
		got = rdat;
		@(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		wb(1'b1, idx, d, 4'h1);
	endtask : wr

	task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
		wb(1'b0, idx, 8'h00, 4'h1);
		chk(nm, e, got);
	endtask : rchk

	// Two edges let the request and then the call register settle.
	task automatic fl(input logic [18:0] f);
		@(posedge clk);
		flags <= f;
		repeat (2) @(posedge clk);
		#1;
	endtask : fl

	task automatic svc(input logic en, input logic rt);
		@(posedge clk);
		take <= en;
		done <= rt;
		@(posedge clk);
		take <= 1'b0;
		done <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : svc

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk("en_main", IMP_IDX_EN_MAIN, 32'h00000000);
		rchk("lvl_main", IMP_IDX_LVL_MAIN, 32'h00000080);
		rchk("en_ext1", IMP_IDX_EN_EXT1, 32'h00000000);
		rchk("lvl_ext1", IMP_IDX_LVL_EXT1, 32'h00000000);
	endtask : t_reset

	task automatic t_regs();
		wr(IMP_IDX_LVL_MAIN, 8'h2a);
		rchk("lvl_main_wr", IMP_IDX_LVL_MAIN, 32'h000000aa);
		wr(IMP_IDX_EN_EXT1, 8'h5c);
		wb(1'b1, IMP_IDX_EN_EXT1, 8'hff, 4'h0);
		wr(IMP_IDX_PAGE, 8'h07);
		rchk("en_ext1_pg", IMP_IDX_EN_EXT1, 32'h0000005c);
		wr(IMP_IDX_EN_MAIN, 8'h81);
		rchk("en_main_pg", IMP_IDX_EN_MAIN, 32'h00000081);
		wr(IMP_IDX_LVL_EXT1, 8'h33);
		rchk("lvl_ext1_off", IMP_IDX_LVL_EXT1, 32'h00000000);
		wr(IMP_IDX_PAGE, 8'h00);
		rchk("lvl_ext1_kept", IMP_IDX_LVL_EXT1, 32'h00000000);
		wr(IMP_IDX_PAGE, 8'h0f);
		wr(IMP_IDX_LVL_EXT1, 8'h33);
		wr(IMP_IDX_PAGE, 8'h00);
		rchk("lvl_ext1_p0", IMP_IDX_LVL_EXT1, 32'h00000033);
		rchk("unmapped", 8'h10, 32'h00000000);
		chk("level", {17'h0, 8'h33, 7'h2a}, {17'h0, lvl});
		wr(IMP_IDX_LVL_MAIN, 8'h00);
		wr(IMP_IDX_LVL_EXT1, 8'h00);
	endtask : t_regs

	task automatic t_gate();
		int i;
		int src [19] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 8, 9, 10, 11, 11, 12, 12, 13, 13, 14};
		wr(IMP_IDX_EN_MAIN, 8'h7f);
		wr(IMP_IDX_EN_EXT1, 8'hff);
		fl(19'h7ffff);
		chk("req_global_off", 32'h0, {17'h0, req});
		wr(IMP_IDX_EN_MAIN, 8'hff);
		for (i = 0; i < 19; i++)
		begin
			fl(19'h00001 << i);
			chk("req_flag", {17'h0, 15'h0001 << src[i]}, {17'h0, req});
		end
		fl(19'h7ffff);
		for (i = 0; i < 15; i++)
		begin
			wr(IMP_IDX_EN_MAIN, i < 7 ? 8'h80 | (8'h01 << i) : 8'h80);
			wr(IMP_IDX_EN_EXT1, i < 7 ? 8'h00 : 8'h01 << (i - 7));
			repeat (2) @(posedge clk);
			#1;
			chk("req_mask", {17'h0, 15'h0001 << i}, {17'h0, req});
		end
	endtask : t_gate

	task automatic t_arb();
		wr(IMP_IDX_EN_MAIN, 8'hff);
		wr(IMP_IDX_EN_EXT1, 8'hff);
		fl(19'h00000);
		@(posedge clk);
		flags <= 19'h00006;
		@(posedge clk);
		#1;
		chk("call_early", 32'h0, {26'h0, call});
		@(posedge clk);
		#1;
		chk("call_low", 32'h00000021, {26'h0, call});
		wr(IMP_IDX_LVL_MAIN, 8'h04);
		repeat (2) @(posedge clk);
		#1;
		chk("call_high", 32'h00000032, {26'h0, call});
		wr(IMP_IDX_LVL_MAIN, 8'h00);
		fl(19'h00002);
		svc(1'b1, 1'b0);
		chk("low_busy", 32'h0, {31'h0, call.req});
		wr(IMP_IDX_LVL_MAIN, 8'h04);
		fl(19'h00006);
		chk("preempt", 32'h00000032, {26'h0, call});
		svc(1'b1, 1'b0);
		chk("high_busy", 32'h0, {31'h0, call.req});
		svc(1'b0, 1'b1);
		chk("high_done", 32'h00000032, {26'h0, call});
	endtask : t_arb

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_regs();
		t_gate();
		t_arb();
		end_of_test();
	end
endmodule : test_interrupt_mask_priority_regs
`default_nettype wire
